// File: logic/pcm_tdm_pkg.sv
// Constants for the PCM time-division port timing block
package pcm_tdm_pkg;
  localparam int OSC_HZ           = 12288000;
  localparam int BIT_CLK_HZ       = 4096000;
  localparam int OSC_PER_BIT      = OSC_HZ / BIT_CLK_HZ;
  localparam int FRAME_PERIOD_NS  = 125000;
  localparam int BITS_PER_FRAME   = (FRAME_PERIOD_NS * (BIT_CLK_HZ / 1000)) / 1000000;
  localparam int FRAME_OSC_CYCLES = BITS_PER_FRAME * OSC_PER_BIT;
  localparam int BIT_CNT_W        = 9;
  localparam int PH_W             = 3;
  localparam int SLOT_W           = 5;
  localparam int BYTE_W           = 8;
  localparam int WORD_W           = SLOT_W + BYTE_W;
  localparam int CFG_W            = 4;
  localparam int CFG_ROLE         = 0;
  localparam int CFG_EARLY        = 3;
  localparam int PER_W            = 11;
  localparam logic [PH_W-1:0]      NOM_LEN   = PH_W'(OSC_PER_BIT);
  localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 9'h000;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT  = 9'h1ff;
  localparam logic [BIT_CNT_W-1:0] ADJ_BIT0  = 9'h1f0;
  localparam logic [BIT_CNT_W-1:0] ADJ_BIT1  = 9'h1f1;
  localparam logic [SLOT_W-1:0]    ADJ_SLOT  = 5'h1f;
  localparam logic [3:0]           BYTE_LAST = 4'hf;
  localparam logic [PER_W-1:0]     PER_LAST  = PER_W'(FRAME_OSC_CYCLES - 1);
endpackage : pcm_tdm_pkg

// File: logic/pcm_tdm_timing.sv
// Bit clock, frame sync and slot capture for the PCM time-division port
// Functional notes
// - Role bit 0 set: block is master, drives bit clock and frame sync.
// - Role bit clear after reset: slave, clock and frame come from outside.
// - Bit 3 set: frame sync one bit clock earlier, sent and expected.
// - Master frame sync every 125 us, one or two corrections of one oscillator cycle each.
// - Clock period correction only inside time slot 31.
// - Bit clock 4.096 MHz with a half-rate companion clock.
// - Data streams at 2.048 Mb/s from a 12.288 MHz oscillator.
`timescale 1ns/1ps
module pcm_tdm_timing
  import pcm_tdm_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              OSCILLATOR_INPUT,
  input  wire logic [CFG_W-1:0]  PORT_CONFIG,
  input  wire logic              ADJ_ENABLE,
  input  wire logic              ADJ_SLOWER,
  input  wire logic              ADJ_TWO_HALVES,
  input  wire logic              BIT_CLOCK_4X_I,
  output logic                   BIT_CLOCK_4X_O,
  output logic                   BIT_CLOCK_4X_OE,
  input  wire logic              FRAME_SYNC_I,
  output logic                   FRAME_SYNC_O,
  output logic                   FRAME_SYNC_OE,
  output logic                   BIT_CLOCK_2X,
  input  wire logic              SERIAL_DATA_LINE_B,
  output logic [BYTE_W-1:0]      RX_DATA,
  output logic [SLOT_W-1:0]      RX_SLOT,
  output logic                   RX_VALID,
  input  wire logic              RX_READY,
  output logic                   RX_OVERRUN,
  input  wire logic              OVERRUN_CLEAR
);
  // Oscillator domain: reset released synchronously
  logic [1:0] lrst_q;
  logic       lrst;

  always_ff @(posedge OSCILLATOR_INPUT or posedge SYS_RST)
  begin
    if (SYS_RST)
      lrst_q <= 2'b11;
    else
      lrst_q <= {lrst_q[0], 1'b0};
  end
  assign lrst = lrst_q[1];

  // Config levels and pins, two flops each before use
  localparam int SW = 8;
  logic [SW-1:0] s1_q, s2_q;
  logic          bclk_prev_q;
  logic          role, early, adj, slow, two, bclk_s, fs_s, data_s;

  always_ff @(posedge OSCILLATOR_INPUT or posedge lrst)
  begin
    if (lrst)
    begin
      s1_q        <= '0;
      s2_q        <= '0;
      bclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= {SERIAL_DATA_LINE_B, FRAME_SYNC_I, BIT_CLOCK_4X_I, ADJ_TWO_HALVES,
                      ADJ_SLOWER, ADJ_ENABLE, PORT_CONFIG[CFG_EARLY], PORT_CONFIG[CFG_ROLE]};
      s2_q        <= s1_q;
      bclk_prev_q <= s2_q[5];
    end
  end
  assign {data_s, fs_s, bclk_s, two, slow, adj, early, role} = s2_q;

  // Bit timing and slot capture
  logic [PH_W-1:0]      ph_q, ph_d, len, half;
  logic [BIT_CNT_W-1:0] bit_q, bit_d, idx;
  logic                 c4_q, c4_d, fs_q, fs_d, c2_q, c2_d, master_q, master_d;
  logic [BYTE_W-1:0]    shift_q, shift_d;
  logic [WORD_W-1:0]    word_q, word_d;
  logic                 tog_q, tog_d;
  logic                 end_m, fall, corr;

  always_comb
  begin
    master_d = role;
    corr = master_q && adj && (bit_q == ADJ_BIT0 || (two && bit_q == ADJ_BIT1));
    len  = corr ? (slow ? NOM_LEN + 1'b1 : NOM_LEN - 1'b1) : NOM_LEN;
    half = len >> 1;
    end_m = ph_q >= len - 1'b1;
    ph_d  = master_q ? (end_m ? '0 : ph_q + 1'b1) : '0;
    bit_d = bit_q;
    idx   = bit_q;
    if (master_q)
    begin
      fall = ph_q == half;
      if (end_m)
        bit_d = bit_q + 1'b1;
    end
    else
    begin
      // Slave counts on the incoming falling edge
      fall = bclk_prev_q && !bclk_s;
      if (fall)
        bit_d = fs_s ? (early ? LAST_BIT : FIRST_BIT) : bit_q + 1'b1;
      idx = bit_d;
    end
    c4_d = master_q && (ph_q < half);
    fs_d = master_q && (bit_q == (early ? LAST_BIT : FIRST_BIT));
    c2_d = !bit_q[0];
    shift_d = shift_q;
    word_d  = word_q;
    tog_d   = tog_q;
    // One data bit spans two bit clocks
    if (fall && idx[0])
    begin
      shift_d = {shift_q[BYTE_W-2:0], data_s};
      if (idx[3:0] == BYTE_LAST)
      begin
        word_d = {idx[BIT_CNT_W-1:4], shift_d};
        tog_d  = !tog_q;
      end
    end
  end

  always_ff @(posedge OSCILLATOR_INPUT or posedge lrst)
  begin
    if (lrst)
    begin
      ph_q     <= '0;
      bit_q    <= FIRST_BIT;
      c4_q     <= 1'b0;
      fs_q     <= 1'b0;
      c2_q     <= 1'b0;
      master_q <= 1'b0;
      shift_q  <= '0;
      word_q   <= '0;
      tog_q    <= 1'b0;
    end
    else
    begin
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      c4_q     <= c4_d;
      fs_q     <= fs_d;
      c2_q     <= c2_d;
      master_q <= master_d;
      shift_q  <= shift_d;
      word_q   <= word_d;
      tog_q    <= tog_d;
    end
  end

  assign BIT_CLOCK_4X_O  = c4_q;
  assign BIT_CLOCK_4X_OE = master_q;
  assign FRAME_SYNC_O    = fs_q;
  assign FRAME_SYNC_OE   = master_q;
  assign BIT_CLOCK_2X    = c2_q;

  // Frame period watch, helper for checking only
  logic [PER_W-1:0] per_q;
  logic             per_ok_q;
  logic [2:0]       cfg_prev_q;

  always_ff @(posedge OSCILLATOR_INPUT or posedge lrst)
  begin
    if (lrst)
    begin
      per_q      <= '0;
      per_ok_q   <= 1'b0;
      cfg_prev_q <= '0;
    end
    else
    begin
      cfg_prev_q <= {role, adj, early};
      if (fs_d && !fs_q)
        per_q <= '0;
      else
        per_q <= per_q + 1'b1;
      if (!master_q || adj || cfg_prev_q != {role, adj, early})
        per_ok_q <= 1'b0;
      else if (fs_d && !fs_q)
        per_ok_q <= 1'b1;
    end
  end

  AST_MASTER_DRIVES: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    $rose(master_q) |-> BIT_CLOCK_4X_OE && FRAME_SYNC_OE ##1 $changed(c4_q))
    else $error("Master does not drive the bit clock");
  AST_SLAVE_QUIET: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    !master_q && !role |=> !BIT_CLOCK_4X_OE && !FRAME_SYNC_OE && !c4_q && !fs_q)
    else $error("Slave drives a link pin");
  AST_EARLY_POS: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    master_q && $rose(fs_q) |-> $past(bit_q) == ($past(early) ? LAST_BIT : FIRST_BIT))
    else $error("Frame sync at wrong bit position");
  AST_FRAME_PERIOD: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    fs_d && !fs_q && per_ok_q |-> per_q == PER_LAST)
    else $error("Frame period is not nominal");
  AST_ADJ_SLOT: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    master_q && $past(master_q) && (ph_q == 3'h3 || (ph_q == '0 && $past(ph_q) == 3'h1))
    |-> $past(bit_q[BIT_CNT_W-1:4]) == ADJ_SLOT)
    else $error("Clock corrected outside slot 31");
  AST_BIT_PERIOD: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    master_q && !corr && ph_q == '0 |-> ##1 ph_q == 3'h1 ##1 ph_q == 3'h2 ##1 ph_q == '0)
    else $error("Bit clock period not three oscillator cycles");
  AST_HALF_ALIGN: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    master_q && $rose(fs_q) && !early |-> c2_q)
    else $error("Half-rate clock not aligned to frame sync");
  AST_BYTE_SLOT: assert property (@(posedge OSCILLATOR_INPUT) disable iff (lrst)
    $changed(tog_q) |-> $past(fall) && $past(idx[3:0]) == BYTE_LAST)
    else $error("Slot byte closed at wrong bit");

  // System domain: toggle crossing, one word held while the buffer is full
  logic [2:0]        t_q;
  logic              new_w;
  logic              pend_q, pend_d, ovr_q, ovr_d, lost;
  logic [WORD_W-1:0] pword_q, pword_d;

  stream_if #(.W(WORD_W)) fill_s ();
  stream_if #(.W(WORD_W)) drain_s ();

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      t_q <= '0;
    else
      t_q <= {t_q[1:0], tog_q};
  end
  assign new_w = t_q[2] ^ t_q[1];

  always_comb
  begin
    pend_d  = pend_q && !fill_s.ready;
    pword_d = pword_q;
    lost    = 1'b0;
    if (new_w)
    begin
      // Word is stable for many bit clocks after its toggle
      if (pend_d)
        lost = 1'b1;
      else
      begin
        pword_d = word_q;
        pend_d  = 1'b1;
      end
    end
    ovr_d = lost || (ovr_q && !OVERRUN_CLEAR);
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pend_q  <= 1'b0;
      pword_q <= '0;
      ovr_q   <= 1'b0;
    end
    else
    begin
      pend_q  <= pend_d;
      pword_q <= pword_d;
      ovr_q   <= ovr_d;
    end
  end

  assign fill_s.valid  = pend_q;
  assign fill_s.data   = pword_q;
  assign drain_s.ready = RX_READY;

  two_entry_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk   (CLK),
    .rst   (SYS_RST),
    .fill  (fill_s),
    .drain (drain_s)
  );

  assign RX_VALID   = drain_s.valid;
  assign RX_SLOT    = drain_s.data[WORD_W-1:BYTE_W];
  assign RX_DATA    = drain_s.data[BYTE_W-1:0];
  assign RX_OVERRUN = ovr_q;

  AST_OVERRUN_SET_WINS: assert property (@(posedge CLK) disable iff (SYS_RST)
    new_w && pend_q && !fill_s.ready |=> RX_OVERRUN)
    else $error("Lost word not flagged");
endmodule : pcm_tdm_timing

// File: logic/stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// File: logic/two_entry_buffer.sv
// Small valid/ready FIFO on the system clock
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  stream_if.snk     fill,
  stream_if.src     drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          push, pop;

  assign fill.ready  = cnt_q != CW'(DEPTH);
  assign drain.valid = cnt_q != '0;
  assign drain.data  = mem_q[rd_q];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = fill.data;
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  AST_NO_OVERFILL: assert property (@(posedge clk) disable iff (rst)
    cnt_q == CW'(DEPTH) && !pop |=> cnt_q == CW'(DEPTH))
    else $error("Buffer lost its fill level");
endmodule : two_entry_buffer

// File: logic/unused.sv
// Intentionally empty
`timescale 1ns/1ps

// File: tb/tb.sv
// Self-checking bench for the PCM port timing block
`timescale 1ns/1ps
module tb;
  import pcm_tdm_pkg::*;
  logic              clk = 1'b0;
  logic              osc = 1'b0;
  logic              rst = 1'b1;
  logic [CFG_W-1:0]  cfg = 4'h0;
  logic              adj_en = 1'b0;
  logic              adj_slow = 1'b0;
  logic              adj_two = 1'b0;
  logic              rx_ready = 1'b1;
  logic              ov_clr = 1'b0;
  logic              run = 1'b0;
  logic              early = 1'b0;
  logic              c4_o, c4_oe, fs_o, fs_oe, c2, rx_valid, rx_ov;
  logic              p_drv, p_c4, p_fs, p_sd;
  logic [BYTE_W-1:0] rx_data;
  logic [SLOT_W-1:0] rx_slot;
  int                miscompares = 0;
  int                cmp_count = 0;
  // Pull-ups hold released lines high
  wire c4_w = c4_oe ? c4_o : (p_drv ? p_c4 : 1'b1);
  wire fs_w = fs_oe ? fs_o : (p_drv ? p_fs : 1'b1);
  wire sd_w = p_drv ? p_sd : 1'b1;

  always #12.5 clk = ~clk;
  always #40 osc = ~osc;

  pcm_tdm_timing dut (.CLK(clk), .SYS_RST(rst), .OSCILLATOR_INPUT(osc), .PORT_CONFIG(cfg),
    .ADJ_ENABLE(adj_en), .ADJ_SLOWER(adj_slow), .ADJ_TWO_HALVES(adj_two),
    .BIT_CLOCK_4X_I(c4_w), .BIT_CLOCK_4X_O(c4_o), .BIT_CLOCK_4X_OE(c4_oe),
    .FRAME_SYNC_I(fs_w), .FRAME_SYNC_O(fs_o), .FRAME_SYNC_OE(fs_oe), .BIT_CLOCK_2X(c2),
    .SERIAL_DATA_LINE_B(sd_w), .RX_DATA(rx_data), .RX_SLOT(rx_slot), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_OVERRUN(rx_ov), .OVERRUN_CLEAR(ov_clr));

  tdm_peer_model peer (.run(run), .early(early), .drv(p_drv), .c4(p_c4), .fs(p_fs),
    .sd(p_sd));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Each valid at a falling edge is a distinct word, ready being high
  task automatic get_word(output logic [4:0] s, output logic [7:0] d);
    int i;
    s = 5'h00;
    d = 8'h00;
    for (i = 0; i < 1000; i++)
    begin
      @(negedge clk);
      if (rx_valid === 1'b1)
      begin
        s = rx_slot;
        d = rx_data;
        return;
      end
    end
    chk("word arrival", 16'h1, 16'h0);
  endtask : get_word

  // Checks a run of consecutive slots; first slot fixed when fs0 >= 0
  task automatic slots(input int cnt, input int fs0);
    logic [4:0] s, s0;
    logic [7:0] d;
    int         k;
    for (k = 0; k < cnt; k++)
    begin
      get_word(s, d);
      if (k == 0)
        s0 = (fs0 >= 0) ? 5'(fs0) : s;
      chk("slot", 16'(5'(s0 + k)), 16'(s));
      chk("byte", 16'(8'(s) ^ 8'ha5), 16'(d));
    end
  endtask : slots

  task automatic t_slave;
    chk("clock enable", 16'h0, 16'(c4_oe));
    chk("sync enable", 16'h0, 16'(fs_oe));
    @(posedge clk) run <= 1'b1;
    slots(8, 0);
    chk("slave clock enable", 16'h0, 16'(c4_oe));
  endtask : t_slave

  task automatic t_stall;
    @(posedge clk) rx_ready <= 1'b0;
    repeat (1600) @(posedge clk);
    @(negedge clk);
    chk("overrun", 16'h1, 16'(rx_ov));
    @(posedge clk) rx_ready <= 1'b1;
    slots(3, -1);
    @(posedge clk) ov_clr <= 1'b1;
    @(posedge clk) ov_clr <= 1'b0;
    @(negedge clk);
    chk("overrun cleared", 16'h0, 16'(rx_ov));
  endtask : t_stall

  task automatic t_early;
    @(posedge clk)
    begin
      cfg <= 4'h8;
      early <= 1'b1;
    end
    // One frame to realign; words meanwhile drain unchecked
    repeat (10500) @(posedge clk);
    slots(4, -1);
  endtask : t_early

  // From one frame sync rise to the next, sampled mid-cycle
  task automatic meas(output int n, output int irr, output int hi, output int tg);
    int   per;
    logic fp, cp, tp;
    n = 0;
    irr = 0;
    hi = 0;
    tg = 0;
    per = -1;
    fp = 1'b1;
    cp = c4_o;
    tp = c2;
    while (n < 3000 && !(fs_o === 1'b1 && fp === 1'b0))
    begin
      fp = fs_o;
      @(negedge osc);
      n++;
      if (per >= 0)
        per++;
      if (fs_o === 1'b1)
        hi++;
      if (c2 !== tp)
        tg++;
      tp = c2;
      if (c4_o === 1'b1 && cp === 1'b0)
      begin
        if (per >= 0 && per != OSC_PER_BIT)
          irr++;
        per = 0;
      end
      cp = c4_o;
    end
  endtask : meas

  task automatic t_master;
    int n, irr, hi, tg, m, dl;
    @(posedge clk)
    begin
      cfg <= 4'h1;
      early <= 1'b0;
      run <= 1'b0;
    end
    repeat (100) @(posedge clk);
    chk("master clock enable", 16'h1, 16'(c4_oe));
    chk("master sync enable", 16'h1, 16'(fs_oe));
    meas(n, irr, hi, tg);
    for (m = 0; m < 5; m++)
    begin
      @(posedge clk)
      begin
        adj_en <= (m > 0);
        adj_slow <= (m < 3);
        adj_two <= (m == 2 || m == 4);
      end
      dl = (m == 0) ? 0 : ((m == 2 || m == 4) ? 2 : 1);
      meas(n, irr, hi, tg);
      chk("frame length", 16'(FRAME_OSC_CYCLES + ((m < 3) ? dl : -dl)), 16'(n));
      chk("odd periods", 16'(dl), 16'(irr));
      chk("sync width", 16'(OSC_PER_BIT), 16'(hi));
      chk("half-rate edges", 16'(BITS_PER_FRAME), 16'(tg));
      chk("half-rate at sync", 16'h1, 16'(c2));
    end
    // Early sync in master: the next pulse comes one bit sooner
    @(posedge clk)
    begin
      cfg <= 4'h9;
      adj_en <= 1'b0;
    end
    meas(n, irr, hi, tg);
    chk("early frame length", 16'(FRAME_OSC_CYCLES - OSC_PER_BIT), 16'(n));
    chk("half-rate at early sync", 16'h0, 16'(c2));
  endtask : t_master

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    t_slave;
    t_stall;
    t_early;
    t_master;
    end_sim;
  end

  initial
  begin
    #2000000;
    miscompares++;
    end_sim;
  end
endmodule : tb

// File: tb/tdm_peer_model.sv
// Behavioural far-side bus master for the PCM port
`timescale 1ns/1ps
module tdm_peer_model #(
  parameter int HALF_NS = 240
) (
  input  wire logic run,
  input  wire logic early,
  output logic      drv,
  output logic      c4,
  output logic      fs,
  output logic      sd
);
  int         b;
  logic [7:0] pat;
  initial
  begin
    drv = 1'b0;
    c4  = 1'b1;
    fs  = 1'b0;
    sd  = 1'b1;
    b   = 0;
    forever
    begin
      @(posedge run);
      drv = 1'b1;
      while (run)
      begin
        pat = 8'(b / 16) ^ 8'ha5;
        c4  = 1'b1;
        fs  = early ? (b == 511) : (b == 0);
        // Inverted off the sampling fall, so a count slip shows
        sd  = pat[7 - (b % 16) / 2] ^ ~b[0];
        #(HALF_NS);
        c4  = 1'b0;
        #(HALF_NS);
        b   = (b + 1) % 512;
      end
      drv = 1'b0;
    end
  end
endmodule : tdm_peer_model
